// [fst_trigger.sv]
// top of the hardware frame-sync trigger: arm, lag, extra delay, frame window
// assumes the host keeps pulse width and spacing; reset held until rails settle
`timescale 1ns/10ps
module fst_trigger
  import fst_pkg::*;
(
  input  wire logic      i_clk,
  input  wire logic      i_rst_b,
  input  wire logic      i_sync_in,
  input  wire fst_cfg_s  i_cfg,
  output fst_stat_s      o_stat
);

  // state group
  fst_state_e       state;
  fst_state_e       next_state;

  // countdown group, shared by the lag and the frame window
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  // status group
  fst_stat_s        next_stat;

  // decoded events shared by the groups
  logic             sync_rise;
  logic             in_armed;
  logic             in_delay;
  logic             in_active;
  logic             take_edge;
  logic             drop_edge;
  logic             lag_done;
  logic             frame_done;
  logic             go_idle;
  logic [CNT_W-1:0] lag_load;
  logic [CNT_W-1:0] frame_load;

  // states in which a sync rise cannot start a frame
  function automatic logic edge_blocked(input fst_state_e s);
    logic blocked;
    blocked = 1'b1;
    unique case (s)
      FST_IDLE:   blocked = 1'b1;
      FST_ARMED:  blocked = 1'b0;
      FST_DELAY:  blocked = 1'b1;
      FST_ACTIVE: blocked = 1'b1;
    endcase
    return blocked;
  endfunction

  // states that count as armed toward the timing engine
  function automatic logic state_armed(input fst_state_e s);
    logic armed;
    armed = 1'b1;
    if (s == FST_IDLE) begin
      armed = 1'b0;
    end
    return armed;
  endfunction

  // last cycle of a countdown; a zero load ends at once
  function automatic logic count_last(input logic [CNT_W-1:0] c);
    logic last;
    last = (c <= CNT_ONE);
    return last;
  endfunction

  // a zero frame length still gives a one-cycle frame
  function automatic logic [CNT_W-1:0] frame_len(input logic [CNT_W-1:0] len);
    logic [CNT_W-1:0] eff;
    eff = len;
    if (len == CNT_ZERO) begin
      eff = CNT_ONE;
    end
    return eff;
  endfunction

  // i_clk is the multiplied 40 MHz reference
  // the synchroniser eats three of the sixteen lag cycles;
  // the package subtracts them so the total stays near the nominal lag
  fst_sync_edge u_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_async (i_sync_in),
    .o_rise  (sync_rise)
  );

  // event decode, shared by all three groups
  // in the armed state a disarm in the same cycle as an edge wins: no frame, no ignore flag
  always_comb begin
    in_armed   = (state == FST_ARMED);
    in_delay   = (state == FST_DELAY);
    in_active  = (state == FST_ACTIVE);
    go_idle    = i_cfg.disarm;
    take_edge  = sync_rise & in_armed & ~go_idle;
    drop_edge  = sync_rise & edge_blocked(state);
    lag_done   = in_delay & count_last(count);
    frame_done = in_active & count_last(count);
    lag_load   = LAG_COUNT + i_cfg.extra_delay;
    frame_load = frame_len(i_cfg.frame_length);
  end

  // state group: next value
  // disarm is not honoured in the lag; the frame already promised goes out
  always_comb begin
    next_state = state;
    unique case (state)
      FST_IDLE: begin
        if (i_cfg.arm) begin
          next_state = FST_ARMED;
        end
      end
      FST_ARMED: begin
        if (go_idle) begin
          next_state = FST_IDLE;
        end else if (take_edge) begin
          next_state = FST_DELAY;
        end
      end
      FST_DELAY: begin
        if (lag_done) begin
          next_state = FST_ACTIVE;
        end
      end
      FST_ACTIVE: begin
        if (frame_done) begin
          if (go_idle) begin
            next_state = FST_IDLE;
          end else begin
            next_state = FST_ARMED;
          end
        end
      end
    endcase
  end

  // state group: register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= FST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // countdown group: next value
  // loaded with lag plus extra delay on an accepted edge,
  // then with the frame length when the lag runs out
  always_comb begin
    next_count = count;
    if (take_edge) begin
      next_count = lag_load;
    end else if (lag_done) begin
      next_count = frame_load;
    end else if (frame_done) begin
      next_count = CNT_ZERO;
    end else if (in_delay || in_active) begin
      next_count = count - CNT_ONE;
    end
  end

  // countdown group: register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count <= CNT_ZERO;
    end else begin
      count <= next_count;
    end
  end

  // status group: next value
  // all flags are registered so the outputs come straight from flip-flops;
  // the levels follow the next state so they line up with the pulses
  always_comb begin
    next_stat              = '0;
    next_stat.armed        = state_armed(next_state);
    next_stat.frame_start  = lag_done;
    next_stat.frame_active = (next_state == FST_ACTIVE);
    next_stat.edge_ignored = drop_edge;
  end

  // status group: register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_stat <= '0;
    end else begin
      o_stat <= next_stat;
    end
  end

endmodule

// [fst_pkg.sv]
// package for the hardware frame-sync trigger: timing constants, states, carriers
// assumes a 100 MHz device clock derived from the 40 MHz reference
package fst_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned REF_CLK_MHZ     = 40;
  localparam int unsigned LAG_NS          = 160;
  // nominal lag minus synchroniser and edge-detect stages, rounded down
  localparam int unsigned SYNC_STAGES     = 3;
  localparam int unsigned LAG_CYC_RAW     = LAG_NS / CLK_PERIOD_NS;
  localparam int unsigned LAG_CYC         = (LAG_CYC_RAW > SYNC_STAGES) ?
                                            (LAG_CYC_RAW - SYNC_STAGES) : 1;
  localparam int unsigned PULSE_MIN_NS    = 25;
  localparam int unsigned PULSE_MAX_NS    = 4000;
  localparam int unsigned PULSE_MIN_CYC   = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_MAX_CYC   = PULSE_MAX_NS / CLK_PERIOD_NS;

  localparam int unsigned CNT_W           = 32;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE    = 32'h0000_0001;
  localparam logic [CNT_W-1:0] LAG_COUNT  = CNT_W'(LAG_CYC);

  typedef enum logic [1:0] {
    FST_IDLE   = 2'b00,
    FST_ARMED  = 2'b01,
    FST_DELAY  = 2'b10,
    FST_ACTIVE = 2'b11
  } fst_state_e;

  // software-side configuration
  typedef struct packed {
    logic             arm;
    logic             disarm;
    logic [CNT_W-1:0] extra_delay;
    logic [CNT_W-1:0] frame_length;
  } fst_cfg_s;

  // status toward the timing engine
  typedef struct packed {
    logic armed;
    logic frame_start;
    logic frame_active;
    logic edge_ignored;
  } fst_stat_s;

endpackage

// [fst_sync_edge.sv]
// two-stage synchroniser with rising-edge detection on the stable stage
// assumes an asynchronous sync pin and the device clock
`timescale 1ns/10ps
module fst_sync_edge
  import fst_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_async,
  output logic      o_rise
);

  logic meta;
  logic stable;
  logic stable_d;
  logic next_rise;

  always_comb begin
    next_rise = stable & ~stable_d;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta     <= 1'b0;
      stable   <= 1'b0;
      stable_d <= 1'b0;
      o_rise   <= 1'b0;
    end else begin
      meta     <= i_async;
      stable   <= meta;
      stable_d <= stable;
      o_rise   <= next_rise;
    end
  end

endmodule

// [fst_trigger_properties.sv]
// checker for the frame-sync trigger, bound to its top
// assumes config is held steady while a frame is pending
`timescale 1ns/10ps
module fst_chk
  import fst_pkg::*;
(
  input wire logic      i_clk,
  input wire logic      i_rst_b,
  input wire logic      i_sync_in,
  input wire fst_cfg_s  i_cfg,
  input wire fst_stat_s o_stat
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // cycles since the last sync rise that came more than 80 cycles after the previously counted one
  logic [31:0] n;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) n <= 32'hff;
    else n <= ($rose(i_sync_in) && n > 32'h50) ? 32'h0 : n + 32'h1;
  end
  sequence frame_s; o_stat.frame_active [*8] ##1 !o_stat.frame_active; endsequence
  sequence one_s; o_stat.frame_start ##1 !o_stat.frame_start; endsequence
  arm_take_a: assert property (!o_stat.armed && i_cfg.arm |=> o_stat.armed)
    else $error("arm lost");
  idle_quiet_a: assert property (!o_stat.armed |-> !o_stat.frame_start)
    else $error("idle start");
  idle_ign_a: assert property (!o_stat.armed && $rose(i_sync_in) |-> ##[2:5] o_stat.edge_ignored)
    else $error("idle edge kept");
  start_arm_a: assert property (o_stat.frame_start |-> o_stat.armed && o_stat.frame_active)
    else $error("start state");
  start_pulse_a: assert property (o_stat.frame_start |-> one_s)
    else $error("start width");
  frame_len_a: assert property (o_stat.frame_start && i_cfg.frame_length == 32'h8 |-> frame_s)
    else $error("frame length");
  lag_time_a: assert property (o_stat.frame_start |-> n - i_cfg.extra_delay inside {[13:19]})
    else $error("lag");
  ign_pulse_a: assert property (o_stat.edge_ignored |=> !o_stat.edge_ignored)
    else $error("ignore width");
endmodule
bind fst_trigger fst_chk fst_chk_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_sync_in(i_sync_in),
  .i_cfg(i_cfg), .o_stat(o_stat));

// [fst_host.sv]
// host model pulsing the sync pin for a requested width
// assumes requests come only while no pulse is out
`timescale 1ns/10ps
module fst_host (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_w,
  input  wire logic       i_go,
  output logic            o_sync
);
  logic [7:0] c = 8'h0;
  always_ff @(posedge i_clk) begin
    if (i_go && c == 8'h0) c <= i_w;
    else if (c != 8'h0) c <= c - 8'h1;
  end
  assign o_sync = c != 8'h0;
endmodule

// [tb.sv]
// self-checking bench for the frame-sync trigger with a host model
// assumes 100 MHz clock and stable config during frames
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
  $display("wrong value %0t %h %h", $time, a, b); end end
module tb;
  import fst_pkg::*;
  logic      i_clk = 0, i_rst_b = 0, go = 0, sync;
  logic [7:0] w = 8'h3;
  fst_cfg_s  cfg = '0;
  fst_stat_s st;
  int miscompares = 0, tests_run = 0, cyc = 0, starts = 0, ign = 0, x_st = 0, x_ig = 1, act = 0;
  always #5 i_clk = ~i_clk;
  fst_host fst_host_i (.i_clk(i_clk), .i_w(w), .i_go(go), .o_sync(sync));
  fst_trigger fst_trigger_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_sync_in(sync),
    .i_cfg(cfg), .o_stat(st));
  always @(negedge i_clk) begin
    cyc++;
    act += (st.frame_active === 1'b1);
    starts += (st.frame_start === 1'b1);
    ign += (st.edge_ignored === 1'b1);
    if (cyc > 5000) begin miscompares++; finish_test(); end
  end
  task automatic pulse(input int gap);
    @(negedge i_clk) go = 1;
    @(negedge i_clk) go = 0;
    repeat (gap) @(negedge i_clk);
  endtask
  task automatic finish_test();
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hecd4));
    cfg.frame_length = 32'h8;
    repeat (3) @(negedge i_clk);
    i_rst_b = 1; // rails assumed settled before release
    pulse(100); // sync while idle is dropped
    `CHK(starts, 0)
    @(negedge i_clk) cfg.arm = 1;
    @(negedge i_clk) cfg.arm = 0;
    for (int k = 0; k < 6; k++) begin
      w = 8'($urandom_range(3, 7)); // 30 to 70 ns, below the 80 ns frame
      cfg.extra_delay = 32'($urandom_range(0, 40));
      pulse(w + 4);
      // odd rounds: second pulse lands in the delay
      if (k % 2) begin pulse(0); x_ig++; end
      repeat (110) @(negedge i_clk); // spacing beyond the frame
      x_st++;
      `CHK(starts, x_st)
      `CHK(ign, x_ig)
    end
    `CHK(act, x_st * 8)
    @(negedge i_clk) cfg.disarm = 1;
    @(negedge i_clk) cfg.disarm = 0;
    repeat (2) @(negedge i_clk);
    `CHK(st.armed, 1'b0)
    finish_test();
  end
endmodule
